//--- hw/load_pkg.sv
// constants and types for the load output and lighting timer
// How it works
// - eight load programs are chosen by one three-bit program code.
// - program one fixed: off below 11.10 V, on above 13.10 V.
// - program two fixed: off below 11.80 V, on above 14.00 V.
// - user hysteresis: off below lower threshold, on above upper threshold.
// - user window: on only between lower and upper threshold, off outside.
// - timed selector: hysteresis start, then load stays on for a set time.
// - always off and always on act on the output at once.
// - voltage programs wait two minutes before the load output changes.
// - program comes from the jumper unless the receive pin option disables it.
// - low battery forces the light off; lighting resumes once voltage recovers.
// - load pin is off when decision off or, with the timer enabled, dim is zero, else on.
// - with the timer disabled the load follows only the load program.
// - with the timer enabled the load needs program and timer both true.
// - sunset action: keep off, fixed interval, until midnight, until sunrise.
// - fixed interval lights at sunset then uses second dim level; zero is off.
// - until sunrise stays lit all night, ignores sunrise action, one dim level.
// - sunrise action: off at sunrise, or on earlier at own level then off.
// - dim levels only count when the transmit pin is set to pwm dimming.
// - solar midnight is the midpoint of the night; second dim level starts there.
// - unsynchronised, midnight is six hours after sunset and night lasts twelve.
// - three sunrise intervals of 24 hours within one hour give learned timing.
// - reset drops synchronisation; settings live outside and are kept.
// - zero detection thresholds mean sunset below 11.4 V, sunrise above 11.9 V.
// - sunset and sunrise detection delays run 0 to 63 minutes, zero is none.
// - virtual load mode drives the transmit pin exactly like the load.
// - pwm dimming on the transmit pin runs at a fixed 160 Hz.
package load_pkg;
  localparam int CLK_HZ          = 50_000_000;
  localparam int SEC_S           = 1;
  localparam int SEC_CYCLES      = CLK_HZ * SEC_S;
  localparam int PWM_HZ          = 160;
  localparam int PWM_STEPS       = 100;
  localparam int PWM_STEP_CYCLES = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int SEC_PER_MIN     = 60;
  localparam int SEC_PER_H       = 3600;
  localparam int QUAL_MIN        = 2;
  localparam int MIDNIGHT_H      = 6;
  localparam int NIGHT_H         = 12;
  localparam int DAY_H           = 24;
  localparam int DAY_TOL_H       = 1;

  localparam logic [11:0] PWM_STEP_LAST = 12'(PWM_STEP_CYCLES - 1);
  localparam logic [6:0]  PWM_PCT_LAST  = 7'(PWM_STEPS - 1);
  localparam logic [21:0] QUAL_SEC      = 22'(QUAL_MIN * SEC_PER_MIN);
  localparam logic [21:0] MIDNIGHT_SEC  = 22'(MIDNIGHT_H * SEC_PER_H);
  localparam logic [21:0] NIGHT_SEC     = 22'(NIGHT_H * SEC_PER_H);
  localparam logic [21:0] DAY_SEC       = 22'(DAY_H * SEC_PER_H);
  localparam logic [21:0] DAY_TOL_SEC   = 22'(DAY_TOL_H * SEC_PER_H);

  localparam logic [15:0] CONV1_OFF_MV  = 16'h2B5C;
  localparam logic [15:0] CONV1_ON_MV   = 16'h332C;
  localparam logic [15:0] CONV2_OFF_MV  = 16'h2E18;
  localparam logic [15:0] CONV2_ON_MV   = 16'h36B0;
  localparam logic [15:0] SUNSET_DEF_MV = 16'h2C88;
  localparam logic [15:0] SUNRISE_DEF_MV = 16'h2E7C;

  localparam logic [1:0] SYNC_DONE = 2'h3;
  localparam logic [6:0] DIM_FULL  = 7'h64;
  localparam logic [6:0] DIM_OFF   = 7'h00;

  typedef enum logic [2:0] {
    PROG_OFF = 3'h0, PROG_BATLIFE = 3'h1, PROG_CONV1 = 3'h2, PROG_CONV2 = 3'h3,
    PROG_ON = 3'h4, PROG_HYST = 3'h5, PROG_WINDOW = 3'h6, PROG_TIMED = 3'h7
  } program_t;
  typedef enum logic [1:0] {
    SS_OFF = 2'h0, SS_FIXED = 2'h1, SS_MIDNIGHT = 2'h2, SS_SUNRISE = 2'h3
  } sunset_t;
  typedef enum logic [2:0] {
    TX_COMM = 3'h0, TX_PULSE = 3'h1, TX_PWM = 3'h2, TX_PWM_INV = 3'h3, TX_VIRTUAL = 3'h4
  } tx_mode_t;
  typedef enum logic [1:0] {
    PH_DAY = 2'h0, PH_FIRST = 2'h1, PH_SECOND = 2'h2, PH_MORNING = 2'h3
  } phase_t;
endpackage

//--- hw/qualify_delay.sv
// condition qualifier: output follows input only after a steady hold time
module qualify_delay (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sec_tick,
  input  wire logic        cond,
  input  wire logic [21:0] delay_sec,
  output logic             q
);
  logic [21:0] cnt;
  logic [21:0] next_cnt;
  logic        next_q;

  always_comb begin
    next_cnt = cnt;
    next_q   = q;
    if (cond == q) begin
      next_cnt = '0; // a lapse restarts the wait
    end else if (cnt >= delay_sec) begin
      next_q   = cond;
      next_cnt = '0;
    end else if (sec_tick) begin
      next_cnt = cnt + 22'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt <= '0;
      q   <= 1'b0;
    end else begin
      cnt <= next_cnt;
      q   <= next_q;
    end
  end

  qual_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !$stable(q) |-> $past(cond) == q && $past(cnt) >= $past(delay_sec))
    else $error("qualified output changed before the hold time ran out");
endmodule // qualify_delay

//--- hw/pwm_dimmer.sv
// fixed-rate pwm of a percent dim level
module pwm_dimmer (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [6:0] level,
  output logic            pwm
);
  logic [11:0] step;
  logic [6:0]  pct;
  logic [11:0] next_step;
  logic [6:0]  next_pct;
  logic        next_pwm;

  always_comb begin
    next_step = step + 12'h001;
    next_pct  = pct;
    if (step == load_pkg::PWM_STEP_LAST) begin
      next_step = '0;
      next_pct  = (pct == load_pkg::PWM_PCT_LAST) ? 7'h00 : pct + 7'h01;
    end
    next_pwm = pct < level; // levels of 100 and above stay high
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      step <= '0;
      pct  <= '0;
      pwm  <= 1'b0;
    end else begin
      step <= next_step;
      pct  <= next_pct;
      pwm  <= next_pwm;
    end
  end
endmodule // pwm_dimmer

//--- hw/load_light_ctrl.sv
// load output decision with lighting timer, sun learning and transmit pin drive
module load_light_ctrl #(
  parameter int SEC_CYCLES = load_pkg::SEC_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] batt_mv,
  input  wire logic [15:0] panel_mv,
  input  wire logic [2:0]  cfg_prog,
  input  wire logic [2:0]  jumper_prog,
  input  wire logic        jumper_en,
  input  wire logic        batlife_on,
  input  wire logic [15:0] user_low_mv,
  input  wire logic [15:0] user_high_mv,
  input  wire logic [15:0] timed_min,
  input  wire logic        light_en,
  input  wire logic [1:0]  sunset_act,
  input  wire logic        sunrise_early,
  input  wire logic [15:0] interval_min,
  input  wire logic [15:0] before_min,
  input  wire logic [6:0]  dim_first,
  input  wire logic [6:0]  dim_second,
  input  wire logic [6:0]  dim_morning,
  input  wire logic [15:0] night_mv,
  input  wire logic [15:0] day_mv,
  input  wire logic [5:0]  night_dly_min,
  input  wire logic [5:0]  day_dly_min,
  input  wire logic [2:0]  tx_mode,
  output logic             load_out,
  output logic             tx_out,
  output logic             tx_drive,
  output logic             night,
  output logic             synced,
  output logic [6:0]       dim_level
);
  localparam logic [21:0] MIN_SEC = 22'(load_pkg::SEC_PER_MIN);

  // one-second tick shared by all timers
  logic [25:0] sec_cnt;
  logic        sec_tick;
  logic [25:0] next_sec_cnt;
  logic        next_sec_tick;

  always_comb begin
    next_sec_tick = sec_cnt == 26'(SEC_CYCLES - 1);
    next_sec_cnt  = next_sec_tick ? 26'h0 : sec_cnt + 26'h1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sec_cnt  <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_cnt  <= next_sec_cnt;
      sec_tick <= next_sec_tick;
    end
  end

  // load program
  load_pkg::program_t prog;
  load_pkg::program_t next_prog;
  logic               load_dec;
  logic               next_load_dec;
  logic               load_q;
  logic               load_q_d;
  logic [21:0]        timed_left;
  logic [21:0]        next_timed_left;
  logic               load_want;
  logic [15:0]        lo_mv;
  logic [15:0]        hi_mv;

  always_comb begin
    next_prog = load_pkg::program_t'(jumper_en ? jumper_prog : cfg_prog);
    lo_mv = user_low_mv;
    hi_mv = user_high_mv;
    if (prog == load_pkg::PROG_CONV1) begin
      lo_mv = load_pkg::CONV1_OFF_MV;
      hi_mv = load_pkg::CONV1_ON_MV;
    end else if (prog == load_pkg::PROG_CONV2) begin
      lo_mv = load_pkg::CONV2_OFF_MV;
      hi_mv = load_pkg::CONV2_ON_MV;
    end
    if (prog == load_pkg::PROG_BATLIFE) begin
      load_want = batlife_on;
    end else if (prog == load_pkg::PROG_WINDOW) begin
      load_want = batt_mv >= lo_mv && batt_mv <= hi_mv;
    end else if (batt_mv < lo_mv) begin
      load_want = 1'b0;
    end else if (batt_mv > hi_mv) begin
      load_want = 1'b1;
    end else begin
      load_want = load_q;
    end
    next_timed_left = timed_left;
    if (load_q && !load_q_d) begin
      next_timed_left = 22'(timed_min) * MIN_SEC;
    end else if (!load_q) begin
      next_timed_left = '0;
    end else if (sec_tick && timed_left != 22'h0) begin
      next_timed_left = timed_left - 22'h1;
    end
    case (prog)
      load_pkg::PROG_OFF:   next_load_dec = 1'b0;
      load_pkg::PROG_ON:    next_load_dec = 1'b1;
      load_pkg::PROG_TIMED: next_load_dec = load_q && timed_left != 22'h0;
      default:              next_load_dec = load_q;
    endcase
  end

  qualify_delay load_qual (
    .clk       (clk),
    .reset_n   (reset_n),
    .sec_tick  (sec_tick),
    .cond      (load_want),
    .delay_sec (load_pkg::QUAL_SEC),
    .q         (load_q)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prog       <= load_pkg::PROG_OFF;
      load_dec   <= 1'b0;
      load_q_d   <= 1'b0;
      timed_left <= '0;
    end else begin
      prog       <= next_prog;
      load_dec   <= next_load_dec;
      load_q_d   <= load_q;
      timed_left <= next_timed_left;
    end
  end

  // sun detection and learning of the night length
  logic        night_q;
  logic        night_q_d;
  logic        night_want;
  logic [15:0] set_mv;
  logic [15:0] rise_mv;
  logic [21:0] sun_dly;
  logic [21:0] night_sec;
  logic [21:0] cycle_sec;
  logic [21:0] night_len;
  logic [1:0]  sync_cnt;
  logic        seen_rise;
  logic [21:0] next_night_sec;
  logic [21:0] next_cycle_sec;
  logic [21:0] next_night_len;
  logic [1:0]  next_sync_cnt;
  logic        next_seen_rise;
  logic        cycle_ok;
  logic [21:0] night_total;
  logic [21:0] midnight_sec;

  always_comb begin
    set_mv  = (night_mv == 16'h0) ? load_pkg::SUNSET_DEF_MV : night_mv;
    rise_mv = (day_mv == 16'h0) ? load_pkg::SUNRISE_DEF_MV : day_mv;
    if (panel_mv < set_mv) begin
      night_want = 1'b1;
    end else if (panel_mv > rise_mv) begin
      night_want = 1'b0;
    end else begin
      night_want = night_q;
    end
    sun_dly = 22'(night_q ? day_dly_min : night_dly_min) * MIN_SEC;
    cycle_ok = cycle_sec + load_pkg::DAY_TOL_SEC >= load_pkg::DAY_SEC &&
               cycle_sec <= load_pkg::DAY_SEC + load_pkg::DAY_TOL_SEC;
    next_night_sec = night_sec;
    next_cycle_sec = cycle_sec;
    next_night_len = night_len;
    next_sync_cnt  = sync_cnt;
    next_seen_rise = seen_rise;
    if (sec_tick && night_sec != 22'h3FFFFF) begin
      next_night_sec = night_sec + 22'h1;
    end
    if (sec_tick && cycle_sec != 22'h3FFFFF) begin
      next_cycle_sec = cycle_sec + 22'h1;
    end
    if (night_q && !night_q_d) begin
      next_night_sec = '0;
    end
    if (!night_q && night_q_d) begin
      next_night_len = night_sec;
      next_cycle_sec = '0;
      next_seen_rise = 1'b1;
      if (seen_rise && cycle_ok) begin
        next_sync_cnt = (sync_cnt == load_pkg::SYNC_DONE) ? sync_cnt : sync_cnt + 2'h1;
      end else if (seen_rise) begin
        next_sync_cnt = '0;
      end
    end
    // learned timing only once three good days are seen
    night_total  = (sync_cnt == load_pkg::SYNC_DONE) ? night_len : load_pkg::NIGHT_SEC;
    midnight_sec = (sync_cnt == load_pkg::SYNC_DONE) ? {1'b0, night_len[21:1]}
                                                     : load_pkg::MIDNIGHT_SEC;
  end

  qualify_delay sun_qual (
    .clk       (clk),
    .reset_n   (reset_n),
    .sec_tick  (sec_tick),
    .cond      (night_want),
    .delay_sec (sun_dly),
    .q         (night_q)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      night_q_d <= 1'b0;
      night_sec <= '0;
      cycle_sec <= '0;
      night_len <= load_pkg::NIGHT_SEC;
      sync_cnt  <= '0; // power loss forgets the sun
      seen_rise <= 1'b0;
    end else begin
      night_q_d <= night_q;
      night_sec <= next_night_sec;
      cycle_sec <= next_cycle_sec;
      night_len <= next_night_len;
      sync_cnt  <= next_sync_cnt;
      seen_rise <= next_seen_rise;
    end
  end

  // timer phase and dim level
  load_pkg::phase_t phase;
  load_pkg::phase_t next_phase;
  logic [6:0]       level;
  logic [6:0]       next_level;
  logic             dim_on;
  logic             early;

  always_comb begin
    dim_on = tx_mode == load_pkg::TX_PWM || tx_mode == load_pkg::TX_PWM_INV;
    early  = sunset_act != load_pkg::SS_SUNRISE && sunrise_early &&
             night_sec + 22'(before_min) * MIN_SEC >= night_total;
    if (!night_q || !night_q_d) begin // night_sec is stale until the sunset edge clears it
      next_phase = load_pkg::PH_DAY;
    end else if (early) begin
      next_phase = load_pkg::PH_MORNING;
    end else if (sunset_act == load_pkg::SS_FIXED &&
                 night_sec >= 22'(interval_min) * MIN_SEC) begin
      next_phase = load_pkg::PH_SECOND;
    end else if (sunset_act == load_pkg::SS_MIDNIGHT && night_sec >= midnight_sec) begin
      next_phase = load_pkg::PH_SECOND;
    end else begin
      next_phase = load_pkg::PH_FIRST;
    end
    case (phase)
      load_pkg::PH_FIRST: begin
        next_level = (sunset_act == load_pkg::SS_OFF) ? load_pkg::DIM_OFF
                   : (dim_on ? dim_first : load_pkg::DIM_FULL);
      end
      load_pkg::PH_SECOND:  next_level = dim_on ? dim_second : load_pkg::DIM_OFF;
      load_pkg::PH_MORNING: next_level = dim_on ? dim_morning : load_pkg::DIM_FULL;
      default:              next_level = load_pkg::DIM_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase <= load_pkg::PH_DAY;
      level <= load_pkg::DIM_OFF;
    end else begin
      phase <= next_phase;
      level <= next_level;
    end
  end

  // outputs; the pwm sits one cycle behind the level it is given
  logic       load_final;
  logic [6:0] pwm_level;
  logic       pwm;
  logic       next_tx_out;
  logic       next_tx_drive;

  always_comb begin
    load_final = load_dec && (!light_en || level != load_pkg::DIM_OFF);
    pwm_level  = !load_dec ? load_pkg::DIM_OFF : (light_en ? level : load_pkg::DIM_FULL);
    case (load_pkg::tx_mode_t'(tx_mode))
      load_pkg::TX_VIRTUAL: next_tx_out = load_final;
      load_pkg::TX_PWM:     next_tx_out = pwm;
      load_pkg::TX_PWM_INV: next_tx_out = !pwm;
      default:              next_tx_out = 1'b0;
    endcase
    // pulse mode and serial traffic are handled outside this block
    next_tx_drive = dim_on || tx_mode == load_pkg::TX_VIRTUAL;
  end

  pwm_dimmer dimmer (
    .clk     (clk),
    .reset_n (reset_n),
    .level   (pwm_level),
    .pwm     (pwm)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      load_out  <= 1'b0;
      tx_out    <= 1'b0;
      tx_drive  <= 1'b0;
      night     <= 1'b0;
      synced    <= 1'b0;
      dim_level <= load_pkg::DIM_OFF;
    end else begin
      load_out  <= load_final;
      tx_out    <= next_tx_out;
      tx_drive  <= next_tx_drive;
      night     <= night_q;
      synced    <= sync_cnt == load_pkg::SYNC_DONE;
      dim_level <= light_en ? level : load_pkg::DIM_FULL;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  force_off_a: assert property (prog == load_pkg::PROG_OFF |=> ##1 !load_out)
    else $error("always off program left the load on");
  force_on_a: assert property (prog == load_pkg::PROG_ON ##1 !light_en |=> load_out)
    else $error("always on program did not switch the load on");
  conv1_low_a: assert property (prog == load_pkg::PROG_CONV1 &&
    batt_mv < load_pkg::CONV1_OFF_MV |-> !load_want)
    else $error("program one wants load on below its off level");
  conv2_high_a: assert property (prog == load_pkg::PROG_CONV2 &&
    batt_mv > load_pkg::CONV2_ON_MV |-> load_want)
    else $error("program two wants load off above its on level");
  window_out_a: assert property (prog == load_pkg::PROG_WINDOW &&
    batt_mv > user_high_mv |-> !load_want)
    else $error("window program wants load on above the band");
  hyst_hold_a: assert property (prog == load_pkg::PROG_HYST && batt_mv >= lo_mv &&
    batt_mv <= hi_mv |-> load_want == load_q)
    else $error("hysteresis program did not hold its state");
  timer_and_a: assert property (light_en && level == load_pkg::DIM_OFF |=> !load_out)
    else $error("load on while the timer level is zero");
  timer_off_a: assert property (!light_en |=> load_out == $past(load_dec))
    else $error("load output differs from program with timer disabled");
  virtual_tx_a: assert property (tx_mode == load_pkg::TX_VIRTUAL |=> tx_out == load_out)
    else $error("virtual load pin does not follow the load");
  midnight_def_a: assert property (sync_cnt != load_pkg::SYNC_DONE |->
    midnight_sec == load_pkg::MIDNIGHT_SEC && night_total == load_pkg::NIGHT_SEC)
    else $error("unsynchronised timing is not the default night");
endmodule // load_light_ctrl

//--- tb/lamp_model.sv
// relay and lamp model standing on the load output
module lamp_model #(
  parameter int SETTLE = 2
) (
  input  wire logic clk,
  input  wire logic load_out,
  output logic      lamp_lit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  initial begin
    cnt = 8'h00;
    lamp_lit = 1'b0;
  end
  // contact moves only after the coil has held its state; a slow relay is a large SETTLE
  always @(posedge clk) begin
    if (load_out === lamp_lit) begin
      cnt <= 8'h00;
    end else if (cnt >= 8'(SETTLE)) begin
      lamp_lit <= load_out;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // lamp_model

//--- tb/load_light_ctrl_tb_top.sv
// self-checking bench of the load decision and lighting timer
module load_light_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEC  = 2;
  localparam int QUAL = 120 * SEC;
  localparam int LO   = QUAL - 2;
  localparam int HI   = QUAL + 8;
  logic        clk = 1'b0;
  logic        reset_n, jumper_en, batlife_on, light_en, sunrise_early;
  logic [15:0] batt_mv, panel_mv, user_low_mv, user_high_mv, timed_min;
  logic [15:0] interval_min, before_min, night_mv, day_mv;
  logic [2:0]  cfg_prog, jumper_prog, tx_mode;
  logic [1:0]  sunset_act;
  logic [6:0]  dim_first, dim_second, dim_morning, dim_level;
  logic [5:0]  night_dly_min, day_dly_min;
  logic        load_out, tx_out, tx_drive, night, synced, lamp_lit;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  load_light_ctrl #(.SEC_CYCLES(SEC)) i_load_light_ctrl (
    .clk(clk), .reset_n(reset_n), .batt_mv(batt_mv), .panel_mv(panel_mv),
    .cfg_prog(cfg_prog), .jumper_prog(jumper_prog), .jumper_en(jumper_en),
    .batlife_on(batlife_on), .user_low_mv(user_low_mv), .user_high_mv(user_high_mv),
    .timed_min(timed_min), .light_en(light_en), .sunset_act(sunset_act),
    .sunrise_early(sunrise_early), .interval_min(interval_min), .before_min(before_min),
    .dim_first(dim_first), .dim_second(dim_second), .dim_morning(dim_morning),
    .night_mv(night_mv), .day_mv(day_mv), .night_dly_min(night_dly_min),
    .day_dly_min(day_dly_min), .tx_mode(tx_mode), .load_out(load_out), .tx_out(tx_out),
    .tx_drive(tx_drive), .night(night), .synced(synced), .dim_level(dim_level));

  lamp_model #(.SETTLE(3)) i_lamp_model (.clk(clk), .load_out(load_out), .lamp_lit(lamp_lit));

  always #10 clk = ~clk;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // counts falling edges until the load reaches exp and judges the delay
  task automatic wait_load(input logic exp, input int lo, input int hi);
    int n;
    n = 0;
    while (load_out !== exp && n < hi + 8) begin
      @(negedge clk);
      n++;
    end
    check("load_out", {15'h0000, exp}, {15'h0000, load_out});
    check("switch delay", 16'h0001, {15'h0000, n >= lo && n <= hi});
  endtask

  task automatic hold_load(input logic exp, input int n);
    logic moved;
    moved = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (load_out !== exp) moved = 1'b1;
    end
    check("load held", 16'h0000, {15'h0000, moved});
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic t_reset();
    check("outputs", 16'h0000, {10'h000, load_out, tx_out, tx_drive, night, synced, 1'b0});
    check("dim_level", 16'h0000, {9'h000, dim_level});
    $display("test reset done");
  endtask

  task automatic t_always();
    tx_mode = 3'h4;
    cfg_prog = 3'h4;
    wait_load(1'b1, 1, 4);
    check("tx_out", 16'h0003, {14'h0000, tx_drive, tx_out});
    repeat (6) @(negedge clk);
    check("lamp", 16'h0001, {15'h0000, lamp_lit});
    cfg_prog = 3'h0;
    wait_load(1'b0, 1, 4);
    check("tx_out", 16'h0002, {14'h0000, tx_drive, tx_out});
    $display("test always done");
  endtask

  task automatic t_fixed();
    batt_mv = 16'h2EE0;
    cfg_prog = 3'h2;
    batt_mv = 16'h3390;
    wait_load(1'b1, LO, HI);
    batt_mv = 16'h2EE0;
    hold_load(1'b1, 2 * QUAL);
    batt_mv = 16'h2AF8;
    hold_load(1'b1, QUAL / 2);
    batt_mv = 16'h2EE0;
    hold_load(1'b1, QUAL);
    batt_mv = 16'h2AF8;
    wait_load(1'b0, LO, HI);
    cfg_prog = 3'h3;
    batt_mv = 16'h34BC;
    hold_load(1'b0, QUAL + 20);
    batt_mv = 16'h3714;
    wait_load(1'b1, LO, HI);
    batt_mv = 16'h2DB4;
    wait_load(1'b0, LO, HI);
    $display("test fixed done");
  endtask

  task automatic t_user();
    user_low_mv = 16'h2EE0;
    user_high_mv = 16'h32C8;
    batt_mv = 16'h34BC;
    cfg_prog = 3'h5;
    wait_load(1'b1, LO, HI);
    batt_mv = 16'h2CEC;
    wait_load(1'b0, LO, HI);
    batt_mv = 16'h30D4;
    hold_load(1'b0, QUAL + 20);
    cfg_prog = 3'h6;
    batt_mv = 16'h30D4;
    wait_load(1'b1, LO, HI);
    batt_mv = 16'h34BC;
    wait_load(1'b0, LO, HI);
    $display("test user done");
  endtask

  task automatic t_timed();
    cfg_prog = 3'h7;
    wait_load(1'b1, LO, HI);
    wait_load(1'b0, 60 * SEC - 4, 60 * SEC + 4);
    cfg_prog = 3'h1;
    batlife_on = 1'b1;
    wait_load(1'b1, 1, 4);
    batlife_on = 1'b0;
    wait_load(1'b0, LO, HI);
    $display("test timed done");
  endtask

  task automatic t_light();
    panel_mv = 16'h3A98;
    cfg_prog = 3'h4;
    wait_load(1'b1, 1, 4);
    light_en = 1'b1;
    sunset_act = 2'h3;
    wait_load(1'b0, 1, 6);
    panel_mv = 16'h2AF8;
    wait_load(1'b1, 1, 8);
    check("night", 16'h0001, {15'h0000, night});
    sunset_act = 2'h0;
    wait_load(1'b0, 1, 6);
    sunset_act = 2'h3;
    wait_load(1'b1, 1, 6);
    cfg_prog = 3'h0;
    wait_load(1'b0, 1, 4);
    panel_mv = 16'h30D4;
    repeat (8) @(negedge clk);
    check("night", 16'h0000, {15'h0000, night});
    light_en = 1'b0;
    $display("test light done");
  endtask

  task automatic t_jumper();
    jumper_prog = 3'h4;
    jumper_en = 1'b1;
    wait_load(1'b1, 1, 4);
    jumper_en = 1'b0;
    wait_load(1'b0, 1, 4);
    $display("test jumper done");
  endtask

  task automatic t_timer();
    tx_mode = 3'h2;
    cfg_prog = 3'h4;
    light_en = 1'b1;
    sunset_act = 2'h1;
    interval_min = 16'h0001;
    panel_mv = 16'h2AF8;
    wait_load(1'b1, 1, 8);
    repeat (4) @(negedge clk);
    check("dim_level", 16'h0064, {9'h000, dim_level});
    check("pwm tx", 16'h0003, {14'h0000, tx_drive, tx_out});
    tx_mode = 3'h3;
    repeat (2) @(negedge clk);
    check("pwm tx", 16'h0002, {14'h0000, tx_drive, tx_out});
    repeat (60 * SEC) @(negedge clk);
    check("dim_level", 16'h0032, {9'h000, dim_level});
    check("load_out", 16'h0001, {15'h0000, load_out});
    tx_mode = 3'h4;
    wait_load(1'b0, 1, 6);
    panel_mv = 16'h30D4;
    repeat (4) @(negedge clk);
    sunset_act = 2'h0;
    sunrise_early = 1'b1;
    before_min = 16'h02CF;
    panel_mv = 16'h2AF8;
    wait_load(1'b1, 60 * SEC, 60 * SEC + 8);
    day_dly_min = 6'h01;
    panel_mv = 16'h30D4;
    wait_load(1'b0, 60 * SEC, 60 * SEC + 8);
    check("synced", 16'h0000, {15'h0000, synced});
    light_en = 1'b0;
    sunrise_early = 1'b0;
    day_dly_min = 6'h00;
    $display("test timer done");
  endtask

  // the waits add up to about 4400 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      stop_test();
    end
  end

  initial begin
    reset_n = 1'b0;
    jumper_en = 1'b0;
    batlife_on = 1'b0;
    light_en = 1'b0;
    sunrise_early = 1'b0;
    batt_mv = 16'h2EE0;
    panel_mv = 16'h3A98;
    user_low_mv = 16'h2EE0;
    user_high_mv = 16'h32C8;
    timed_min = 16'h0001;
    interval_min = 16'h003C;
    before_min = 16'h003C;
    night_mv = 16'h0000;
    day_mv = 16'h0000;
    cfg_prog = 3'h0;
    jumper_prog = 3'h0;
    tx_mode = 3'h0;
    sunset_act = 2'h0;
    dim_first = 7'h64;
    dim_second = 7'h32;
    dim_morning = 7'h64;
    night_dly_min = 6'h00;
    day_dly_min = 6'h00;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_always();
    t_fixed();
    t_user();
    t_timed();
    t_light();
    t_jumper();
    t_timer();
    stop_test();
  end
endmodule // load_light_ctrl_tb_top
